// File: hw/ssos_pkg.sv
// Shared constants and types of the servo status output selector
package ssos_pkg;

  // Clock and time base
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam logic [7:0] DELAY_MAX_MS = 8'hc8;

  // Widths and counts
  localparam int N_TERM = 4;
  localparam int CODE_W = 5;
  localparam int VEL_W = 16;
  localparam int POS_W = 32;
  localparam int AXI_AW = 6;
  localparam int SYNC_N = 3;
  localparam int FUNC_STRIDE = 8;

  // Register byte offsets
  localparam logic [AXI_AW-1:0] FUNC_OFF = 6'h00;
  localparam logic [AXI_AW-1:0] POL_OFF = 6'h04;
  localparam logic [AXI_AW-1:0] STANDSTILL_OFF = 6'h08;
  localparam logic [AXI_AW-1:0] IN_POS_OFF = 6'h0c;
  localparam logic [AXI_AW-1:0] SPD_REACH_OFF = 6'h10;
  localparam logic [AXI_AW-1:0] TRQ_REACH_OFF = 6'h14;
  localparam logic [AXI_AW-1:0] CLOSE_OFF = 6'h18;
  localparam logic [AXI_AW-1:0] AGREE_OFF = 6'h1c;
  localparam logic [AXI_AW-1:0] DELAY_OFF = 6'h20;
  localparam logic [AXI_AW-1:0] FLAGS_OFF = 6'h24;
  localparam logic [AXI_AW-1:0] TERM_OFF = 6'h28;

  // Polarity register fields
  localparam int POL_SPD_BIT = 0;
  localparam int POL_TRQ_BIT = 1;

  // Reset values
  localparam logic [CODE_W-1:0] RST_CODE = 5'h00;
  localparam logic [1:0] RST_POL = 2'h0;
  localparam logic [31:0] RST_THR = 32'h0000000a;
  localparam logic [7:0] RST_DELAY = 8'h00;

  // Output function codes
  localparam logic [CODE_W-1:0] FN_ON = 5'h01;
  localparam logic [CODE_W-1:0] FN_READY = 5'h02;
  localparam logic [CODE_W-1:0] FN_FAULT_FREE = 5'h03;
  localparam logic [CODE_W-1:0] FN_STANDSTILL = 5'h04;
  localparam logic [CODE_W-1:0] FN_IN_POS = 5'h05;
  localparam logic [CODE_W-1:0] FN_SPD_REACH = 5'h06;
  localparam logic [CODE_W-1:0] FN_TRQ_REACH = 5'h07;
  localparam logic [CODE_W-1:0] FN_BRAKE = 5'h08;
  localparam logic [CODE_W-1:0] FN_RUN = 5'h09;
  localparam logic [CODE_W-1:0] FN_CLOSE = 5'h0a;
  localparam logic [CODE_W-1:0] FN_TRQ_LIM = 5'h0b;
  localparam logic [CODE_W-1:0] FN_SPD_LIM = 5'h0c;
  localparam logic [CODE_W-1:0] FN_AGREE = 5'h0d;
  localparam logic [CODE_W-1:0] FN_HOME = 5'h0f;
  localparam logic [CODE_W-1:0] FN_CMD_DONE = 5'h10;
  localparam logic [CODE_W-1:0] FN_INDEX = 5'h12;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control mode reported by the drive
  typedef enum logic [1:0] {
    ssos_mode_pos = 2'b00,
    ssos_mode_spd = 2'b01,
    ssos_mode_trq = 2'b10,
    ssos_mode_idle = 2'b11
  } ssos_mode_t;

endpackage

// File: hw/ssos_done_if.sv
// Link between the selector and its completion delay timer
`timescale 1ns/1ns
interface ssos_done_if;
  logic start;
  logic [7:0] delay_ms;
  logic done;
  modport timer (input start, input delay_ms, output done);
  modport user (output start, output delay_ms, input done);
endinterface

// File: hw/ssos_done_timer.sv
// Millisecond delay from command completion to the done flag
`timescale 1ns/1ns
module ssos_done_timer import ssos_pkg::*; #(
  parameter int P_CYC_PER_MS = CYC_PER_MS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  ssos_done_if.timer tmr
);

  localparam int PRE_W = $clog2(P_CYC_PER_MS + 1);

  logic [PRE_W-1:0] pre_reg;
  logic [7:0] ms_reg;
  logic done_reg;

  // Count whole milliseconds while completion holds; a drop restarts the wait
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_reg <= '0;
      ms_reg <= 8'h00;
      done_reg <= 1'b0;
    end else if (!tmr.start) begin
      pre_reg <= '0;
      ms_reg <= 8'h00;
      done_reg <= 1'b0;
    end else if (ms_reg >= tmr.delay_ms) begin
      done_reg <= 1'b1;
    end else if (pre_reg == PRE_W'(P_CYC_PER_MS - 1)) begin
      pre_reg <= '0;
      ms_reg <= ms_reg + 8'h01;
    end else begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  assign tmr.done = done_reg;

endmodule

// File: hw/ssos_top.sv
// Output terminal function selector with its register slave
`timescale 1ns/1ns
module ssos_top import ssos_pkg::*; #(
  parameter int P_CYC_PER_MS = CYC_PER_MS,
  parameter int P_VEL_W = VEL_W,
  parameter int P_POS_W = POS_W
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [AXI_AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [AXI_AW-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire ssos_mode_t i_ctrl_mode,
  input wire logic i_main_power_ok,
  input wire logic i_alarm,
  input wire logic signed [P_VEL_W-1:0] i_motor_speed,
  input wire logic signed [P_VEL_W-1:0] i_cmd_speed,
  input wire logic signed [P_VEL_W-1:0] i_motor_torque,
  input wire logic signed [P_POS_W-1:0] i_pos_deviation,
  input wire logic i_torque_at_limit,
  input wire logic i_speed_at_limit,
  input wire logic i_brake_release,
  input wire logic i_motor_energized,
  input wire logic i_home_done,
  input wire logic i_move_finished,
  input wire logic i_index_pin,
  output logic [N_TERM-1:0] o_terminal
);

  localparam int VW = P_VEL_W + 1;

  // Configuration registers
  logic [CODE_W-1:0] code_reg [N_TERM];
  logic [1:0] pol_reg;
  logic [P_VEL_W-1:0] standstill_threshold_reg;
  logic [P_POS_W-1:0] in_position_threshold_reg;
  logic [P_VEL_W-1:0] speed_reached_threshold_reg;
  logic [P_VEL_W-1:0] torque_reached_threshold_reg;
  logic [P_POS_W-1:0] close_target_threshold_reg;
  logic [P_VEL_W-1:0] speed_agreement_threshold_reg;
  logic [7:0] command_done_delay_reg;

  // Bus state
  logic aw_held_reg;
  logic w_held_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  // Status path
  logic [SYNC_N-1:0] index_sync_reg;
  logic index_level_reg;
  logic [N_TERM-1:0] terminal_reg;
  logic [31:0] flag_vec;
  logic [31:0] func_word;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic wr_fire;
  logic move_command_done;

  // Signed-extend then take the magnitude; one extra bit keeps the
  // most negative value and speed differences from wrapping
  function automatic logic [VW-1:0] mag_v(input logic signed [VW-1:0] v);
    return v[VW-1] ? VW'(-v) : v;
  endfunction

  function automatic logic [P_POS_W:0] mag_p(input logic signed [P_POS_W:0] v);
    return v[P_POS_W] ? (P_POS_W + 1)'(-v) : v;
  endfunction

  // Merge write data into an old word by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // True for any word this slave answers with OKAY
  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] w;
    w = {a[AXI_AW-1:2], 2'b00};
    return (w <= TERM_OFF);
  endfunction

  // Completion delay timer
  ssos_done_if done_bus();

  assign done_bus.start = i_move_finished;
  assign done_bus.delay_ms = command_done_delay_reg;
  assign move_command_done = done_bus.done;

  ssos_done_timer #(
    .P_CYC_PER_MS(P_CYC_PER_MS)
  ) u_done_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .tmr(done_bus)
  );

  // Index pin crosses in from the encoder; accept a change once two stages agree
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      index_sync_reg <= '0;
      index_level_reg <= 1'b0;
    end else begin
      index_sync_reg <= {index_sync_reg[SYNC_N-2:0], i_index_pin};
      if (index_sync_reg[1] == index_sync_reg[2]) begin
        index_level_reg <= index_sync_reg[1];
      end
    end
  end

  // Status condition per function code; unlisted codes stay zero
  always_comb begin
    logic [VW-1:0] spd_mag;
    logic [VW-1:0] trq_mag;
    logic [VW-1:0] err_mag;
    logic [P_POS_W:0] dev_mag;
    logic spd_trq_mode;
    logic spd_over;
    logic trq_over;
    spd_mag = mag_v(VW'(i_motor_speed));
    trq_mag = mag_v(VW'(i_motor_torque));
    err_mag = mag_v(VW'(i_motor_speed) - VW'(i_cmd_speed));
    dev_mag = mag_p((P_POS_W + 1)'(i_pos_deviation));
    spd_trq_mode = (i_ctrl_mode == ssos_mode_spd) || (i_ctrl_mode == ssos_mode_trq);
    spd_over = spd_mag > VW'(speed_reached_threshold_reg);
    trq_over = trq_mag > VW'(torque_reached_threshold_reg);
    flag_vec = '0;
    flag_vec[FN_ON] = 1'b1;
    flag_vec[FN_READY] = i_main_power_ok && !i_alarm;
    flag_vec[FN_FAULT_FREE] = !i_alarm;
    flag_vec[FN_STANDSTILL] = spd_trq_mode && (spd_mag < VW'(standstill_threshold_reg));
    flag_vec[FN_IN_POS] = (i_ctrl_mode == ssos_mode_pos) &&
                          (dev_mag < (P_POS_W + 1)'(in_position_threshold_reg));
    flag_vec[FN_SPD_REACH] = spd_trq_mode && (spd_over ^ pol_reg[POL_SPD_BIT]);
    flag_vec[FN_TRQ_REACH] = trq_over ^ pol_reg[POL_TRQ_BIT];
    flag_vec[FN_BRAKE] = i_brake_release;
    flag_vec[FN_RUN] = i_motor_energized;
    flag_vec[FN_CLOSE] = (i_ctrl_mode == ssos_mode_pos) &&
                         (dev_mag < (P_POS_W + 1)'(close_target_threshold_reg));
    flag_vec[FN_TRQ_LIM] = i_torque_at_limit;
    flag_vec[FN_SPD_LIM] = (i_ctrl_mode == ssos_mode_trq) && i_speed_at_limit;
    flag_vec[FN_AGREE] = err_mag < VW'(speed_agreement_threshold_reg);
    flag_vec[FN_HOME] = i_home_done;
    flag_vec[FN_CMD_DONE] = move_command_done;
    flag_vec[FN_INDEX] = index_level_reg;
  end

  // Each terminal picks its flag by its own code, registered for clean pins
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      terminal_reg <= '0;
    end else begin
      for (int k = 0; k < N_TERM; k++) begin
        terminal_reg[k] <= flag_vec[code_reg[k]];
      end
    end
  end

  assign o_terminal = terminal_reg;

  // Packed view of the four function codes
  always_comb begin
    func_word = '0;
    for (int k = 0; k < N_TERM; k++) begin
      func_word[k*FUNC_STRIDE +: CODE_W] = code_reg[k];
    end
  end

  // Write channels are taken independently and held until the write is done
  assign o_s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign o_s_axi_wready = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= i_s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= i_s_axi_wdata;
      wstrb_reg <= i_s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Write response; unmapped addresses get SLVERR and change nothing
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && i_s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;

  // Old contents of the addressed word, merged with the strobed bytes
  always_comb begin
    logic [AXI_AW-1:0] a;
    a = {awaddr_reg[AXI_AW-1:2], 2'b00};
    wr_word = 32'h00000000;
    if (a == FUNC_OFF) begin
      wr_word = func_word;
    end else if (a == POL_OFF) begin
      wr_word = 32'(pol_reg);
    end else if (a == STANDSTILL_OFF) begin
      wr_word = 32'(standstill_threshold_reg);
    end else if (a == IN_POS_OFF) begin
      wr_word = 32'(in_position_threshold_reg);
    end else if (a == SPD_REACH_OFF) begin
      wr_word = 32'(speed_reached_threshold_reg);
    end else if (a == TRQ_REACH_OFF) begin
      wr_word = 32'(torque_reached_threshold_reg);
    end else if (a == CLOSE_OFF) begin
      wr_word = 32'(close_target_threshold_reg);
    end else if (a == AGREE_OFF) begin
      wr_word = 32'(speed_agreement_threshold_reg);
    end else if (a == DELAY_OFF) begin
      wr_word = 32'(command_done_delay_reg);
    end
    wr_word = merge(wr_word, wdata_reg, wstrb_reg);
  end

  // Register updates; status words ignore writes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < N_TERM; k++) begin
        code_reg[k] <= RST_CODE;
      end
      pol_reg <= RST_POL;
      standstill_threshold_reg <= P_VEL_W'(RST_THR);
      in_position_threshold_reg <= P_POS_W'(RST_THR);
      speed_reached_threshold_reg <= P_VEL_W'(RST_THR);
      torque_reached_threshold_reg <= P_VEL_W'(RST_THR);
      close_target_threshold_reg <= P_POS_W'(RST_THR);
      speed_agreement_threshold_reg <= P_VEL_W'(RST_THR);
      command_done_delay_reg <= RST_DELAY;
    end else if (wr_fire) begin
      if ({awaddr_reg[AXI_AW-1:2], 2'b00} == FUNC_OFF) begin
        for (int k = 0; k < N_TERM; k++) begin
          code_reg[k] <= wr_word[k*FUNC_STRIDE +: CODE_W];
        end
      end else if ({awaddr_reg[AXI_AW-1:2], 2'b00} == POL_OFF) begin
        pol_reg <= wr_word[1:0];
      end else if ({awaddr_reg[AXI_AW-1:2], 2'b00} == STANDSTILL_OFF) begin
        standstill_threshold_reg <= P_VEL_W'(wr_word);
      end else if ({awaddr_reg[AXI_AW-1:2], 2'b00} == IN_POS_OFF) begin
        in_position_threshold_reg <= P_POS_W'(wr_word);
      end else if ({awaddr_reg[AXI_AW-1:2], 2'b00} == SPD_REACH_OFF) begin
        speed_reached_threshold_reg <= P_VEL_W'(wr_word);
      end else if ({awaddr_reg[AXI_AW-1:2], 2'b00} == TRQ_REACH_OFF) begin
        torque_reached_threshold_reg <= P_VEL_W'(wr_word);
      end else if ({awaddr_reg[AXI_AW-1:2], 2'b00} == CLOSE_OFF) begin
        close_target_threshold_reg <= P_POS_W'(wr_word);
      end else if ({awaddr_reg[AXI_AW-1:2], 2'b00} == AGREE_OFF) begin
        speed_agreement_threshold_reg <= P_VEL_W'(wr_word);
      end else if ({awaddr_reg[AXI_AW-1:2], 2'b00} == DELAY_OFF) begin
        // Longer delays clip to the top of the range
        if (wr_word[7:0] > DELAY_MAX_MS || wr_word[31:8] != 24'h000000) begin
          command_done_delay_reg <= DELAY_MAX_MS;
        end else begin
          command_done_delay_reg <= wr_word[7:0];
        end
      end
    end
  end

  // Read data multiplexer
  always_comb begin
    logic [AXI_AW-1:0] a;
    a = {i_s_axi_araddr[AXI_AW-1:2], 2'b00};
    rd_word = 32'h00000000;
    if (a == FUNC_OFF) begin
      rd_word = func_word;
    end else if (a == POL_OFF) begin
      rd_word = 32'(pol_reg);
    end else if (a == STANDSTILL_OFF) begin
      rd_word = 32'(standstill_threshold_reg);
    end else if (a == IN_POS_OFF) begin
      rd_word = 32'(in_position_threshold_reg);
    end else if (a == SPD_REACH_OFF) begin
      rd_word = 32'(speed_reached_threshold_reg);
    end else if (a == TRQ_REACH_OFF) begin
      rd_word = 32'(torque_reached_threshold_reg);
    end else if (a == CLOSE_OFF) begin
      rd_word = 32'(close_target_threshold_reg);
    end else if (a == AGREE_OFF) begin
      rd_word = 32'(speed_agreement_threshold_reg);
    end else if (a == DELAY_OFF) begin
      rd_word = 32'(command_done_delay_reg);
    end else if (a == FLAGS_OFF) begin
      rd_word = flag_vec;
    end else if (a == TERM_OFF) begin
      rd_word = 32'(terminal_reg);
    end
  end

  // Read channel; one read outstanding, data held until taken
  assign o_s_axi_arready = !rvalid_reg;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= mapped(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= rd_word;
    end else if (rvalid_reg && i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rresp = rresp_reg;
  assign o_s_axi_rdata = rdata_reg;

endmodule

// File: verif/ssos_top_checker.sv
// Bus and terminal assertions for the servo status output selector
`timescale 1ns/1ns
module ssos_top_checker import ssos_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [AXI_AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [AXI_AW-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_main_power_ok,
  input wire logic i_alarm,
  input wire logic i_brake_release,
  input wire logic i_motor_energized,
  input wire logic [N_TERM-1:0] o_terminal
);
  logic wr_busy;
  logic [CODE_W-1:0] code0;
  logic [AXI_AW-1:0] aw_q;
  logic [31:0] w_q;

  // Write in flight; terminal checks pause since the code may change mid-way
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_busy <= 1'b0;
    end else if (o_s_axi_bvalid && i_s_axi_bready) begin
      wr_busy <= 1'b0;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      wr_busy <= 1'b1;
    end
  end

  // Shadow of terminal 0 code; assumes full-word writes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_q <= '0;
      w_q <= '0;
      code0 <= RST_CODE;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) aw_q <= i_s_axi_awaddr;
      if (i_s_axi_wvalid && o_s_axi_wready) w_q <= i_s_axi_wdata;
      if (o_s_axi_bvalid && i_s_axi_bready && o_s_axi_bresp == RESP_OKAY && aw_q[5:2] == 4'h0) code0 <= w_q[4:0];
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_quiet; !wr_busy && !$past(wr_busy); endsequence
  sequence s_wr_taken; i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready; endsequence
  sequence s_rd_taken; i_s_axi_arvalid && o_s_axi_arready; endsequence

  property p_code_on; s_quiet ##0 (code0 == FN_ON) |=> o_terminal[0]; endproperty
  property p_ready; s_quiet ##0 (code0 == FN_READY) |=> o_terminal[0] == ($past(i_main_power_ok) && !$past(i_alarm));
  endproperty
  property p_brake; s_quiet ##0 (code0 == FN_BRAKE) |=> o_terminal[0] == $past(i_brake_release); endproperty
  property p_run; s_quiet ##0 (code0 == FN_RUN) |=> o_terminal[0] == $past(i_motor_energized); endproperty
  property p_undef;
    s_quiet ##0 (code0 == 5'h00 || code0 == 5'h0e || code0 == 5'h11 || code0 > 5'h12) |=> !o_terminal[0];
  endproperty
  property p_write_answer; s_wr_taken |-> ##2 o_s_axi_bvalid; endproperty
  property p_b_release; o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid && o_s_axi_awready; endproperty
  property p_w_refused; o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready; endproperty
  property p_read_answer; s_rd_taken |=> o_s_axi_rvalid && !o_s_axi_arready; endproperty
  property p_read_unmapped;
    s_rd_taken ##0 (i_s_axi_araddr[5:2] > 4'ha) |=> o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0;
  endproperty
  property p_r_release; o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid; endproperty

  a_code_on: assert property (p_code_on) else $error("code one terminal off");
  a_ready: assert property (p_ready) else $error("ready terminal wrong");
  a_brake: assert property (p_brake) else $error("brake terminal wrong");
  a_run: assert property (p_run) else $error("running terminal wrong");
  a_undef: assert property (p_undef) else $error("undefined code drives terminal");
  a_write_answer: assert property (p_write_answer) else $error("write response late");
  a_b_release: assert property (p_b_release) else $error("write response not released");
  a_w_refused: assert property (p_w_refused) else $error("write accepted while answering");
  a_read_answer: assert property (p_read_answer) else $error("read response late");
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not refused");
  a_r_release: assert property (p_r_release) else $error("read response not released");
endmodule

// File: verif/ssos_plc_model.sv
// Machine controller model that latches the output terminals
`timescale 1ns/1ns
module ssos_plc_model (
  input wire logic i_ref_clk,
  input wire logic [3:0] i_terminal,
  output logic [3:0] o_seen
);
  // Input card latch; adds one cycle, as a real controller scan would
  always_ff @(posedge i_ref_clk) begin
    o_seen <= i_terminal;
  end
endmodule

// File: verif/ssos_top_tb.sv
// Self-checking bench for the servo status output selector
`timescale 1ns/1ns
module ssos_top_tb import ssos_pkg::*; ;
  logic i_ref_clk, i_rst, i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready;
  logic o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready, o_s_axi_rvalid, i_s_axi_rready;
  logic [5:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd_d;
  logic [3:0] i_s_axi_wstrb, o_terminal, seen;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp;
  ssos_mode_t i_ctrl_mode;
  logic i_main_power_ok, i_alarm, i_torque_at_limit, i_speed_at_limit, i_brake_release;
  logic i_motor_energized, i_home_done, i_move_finished, i_index_pin;
  logic signed [15:0] i_motor_speed, i_cmd_speed, i_motor_torque;
  logic signed [31:0] i_pos_deviation;
  logic [4:0] codes [21] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 15, 16, 18, 0, 14, 17, 19, 31};
  logic def;
  int err_count, n_compared, cyc;

  // Short millisecond so the 200 ms ceiling fits the run
  ssos_top #(.P_CYC_PER_MS(4)) u_dut (.*);
  ssos_plc_model u_plc (.i_ref_clk, .i_terminal(o_terminal), .o_seen(seen));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (o_s_axi_bvalid !== 1'b1);
    resp = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge i_ref_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (o_s_axi_rvalid !== 1'b1);
    i_s_axi_rready <= 1'b0;
    chk("read data", ed, o_s_axi_rdata);
    chk("read response", {30'h0, er}, {30'h0, o_s_axi_rresp});
  endtask

  // Drive the status inputs so that code c should read on or off
  task automatic apply(input logic [4:0] c, input logic on, input logic [3:0] exp);
    logic u;
    u = on && (c == 5'h00 || c == 5'h0e || c == 5'h11 || c > 5'h12);
    @(posedge i_ref_clk);
    i_ctrl_mode <= (c == FN_IN_POS || c == FN_CLOSE) ? ssos_mode_pos : (c == FN_SPD_LIM) ? ssos_mode_trq :
      (c == FN_STANDSTILL || c == FN_SPD_REACH) ? ssos_mode_spd : ssos_mode_idle;
    i_main_power_ok <= (c == FN_READY && on) || u;
    i_alarm <= !(((c == FN_READY || c == FN_FAULT_FREE) && on) || u);
    i_motor_speed <= c == FN_STANDSTILL ? (on ? -16'sd5 : -16'sd20) : c == FN_SPD_REACH ? (on ? 16'sd20 : 16'sd5) :
      c == FN_AGREE ? 16'sd100 : 16'sd0;
    i_cmd_speed <= c == FN_AGREE ? (on ? 16'sd95 : 16'sd150) : 16'sd0;
    i_motor_torque <= c == FN_TRQ_REACH ? (on ? -16'sd30 : 16'sd2) : 16'sd0;
    i_pos_deviation <= c == FN_IN_POS ? (on ? -32'sd3 : 32'sd50) : c == FN_CLOSE ? (on ? 32'sd5 : -32'sd40) : 32'sd0;
    i_torque_at_limit <= (c == FN_TRQ_LIM && on) || u;
    i_speed_at_limit <= (c == FN_SPD_LIM && on) || u;
    i_brake_release <= (c == FN_BRAKE && on) || u;
    i_motor_energized <= (c == FN_RUN && on) || u;
    i_home_done <= (c == FN_HOME && on) || u;
    i_move_finished <= (c == FN_CMD_DONE && on) || u;
    i_index_pin <= (c == FN_INDEX && on) || u;
    repeat (7) @(posedge i_ref_clk);
    chk("terminals", {28'h0, exp}, {28'h0, seen});
  endtask

  // Completion output must stay off early and be on by the late check
  task automatic done_chk(input logic [31:0] dly, input int early, input int late);
    wr(DELAY_OFF, dly);
    @(posedge i_ref_clk);
    i_move_finished <= 1'b1;
    repeat (early) @(posedge i_ref_clk);
    chk("done early", 32'h0, {28'h0, o_terminal});
    repeat (late - early) @(posedge i_ref_clk);
    chk("done late", 32'hf, {28'h0, o_terminal});
    i_move_finished <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    chk("done dropped", 32'h0, {28'h0, o_terminal});
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Run ceiling, well above the roughly 1400 cycles the tests need
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = 5'h00;
    i_s_axi_awaddr = 6'h00;
    i_s_axi_araddr = 6'h00;
    i_s_axi_wdata = 32'h0;
    i_s_axi_wstrb = 4'hf;
    cyc = 0;
    i_rst = 1'b1;
    apply(5'h00, 1'b0, 4'h0);
    i_rst <= 1'b0;
    for (int k = 0; k < 9; k++) rd(6'(4 * k), (k < 2 || k == 8) ? 32'h0 : RST_THR, RESP_OKAY);
    rd(6'h2c, 32'h0, RESP_SLVERR);
    wr(6'h3c, 32'h1);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
    wr(TERM_OFF, 32'hf);
    chk("read-only write", {30'h0, RESP_OKAY}, {30'h0, resp});
    wr(DELAY_OFF, 32'hff);
    rd(DELAY_OFF, {24'h0, DELAY_MAX_MS}, RESP_OKAY);
    $display("test registers done");
    wr(FUNC_OFF, {4{8'h10}});
    done_chk(32'h2, 8, 12);
    done_chk(32'hc8, 790, 810);
    wr(DELAY_OFF, 32'h0);
    $display("test completion delay done");
    foreach (codes[i]) begin
      def = !(codes[i] == 5'h00 || codes[i] == 5'h0e || codes[i] == 5'h11 || codes[i] > 5'h12);
      wr(FUNC_OFF, {4{3'h0, codes[i]}});
      apply(codes[i], 1'b1, {4{def}});
      apply(codes[i], 1'b0, {4{codes[i] == FN_ON}});
    end
    $display("test function codes done");
    wr(FUNC_OFF, {4{8'h06}});
    wr(POL_OFF, 32'h3);
    apply(FN_SPD_REACH, 1'b1, 4'h0);
    apply(FN_SPD_REACH, 1'b0, 4'hf);
    wr(FUNC_OFF, {4{8'h07}});
    apply(FN_TRQ_REACH, 1'b1, 4'h0);
    wr(FUNC_OFF, {4{8'h04}});
    wr(STANDSTILL_OFF, 32'h5);
    apply(FN_STANDSTILL, 1'b1, 4'h0);
    $display("test polarity and threshold done");
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(FUNC_OFF, 32'h0, RESP_OKAY);
    rd(POL_OFF, 32'h0, RESP_OKAY);
    rd(TERM_OFF, 32'h0, RESP_OKAY);
    apply(FN_ON, 1'b1, 4'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule

bind ssos_top ssos_top_checker u_chk (.*);
